// ==== inc/jps_pkg.sv ====
// ---------------------------------------------------------------
// package for the boundary-scan pin sharing and probe block
// ---------------------------------------------------------------
// holds register map, tap codes, instruction codes and pin types;
// assumes a 25 MHz system clock and an avalon-mm register master.
package jps_pkg;
  // register map (byte addresses)
  localparam logic [3:0] JPS_OFS_CTRL = 4'h0;
  localparam logic [3:0] JPS_OFS_STAT = 4'h4;
  localparam logic [3:0] JPS_OFS_SEL = 4'h8;
  // control bit positions
  localparam int JPS_CTRL_DEDIC = 0;
  localparam int JPS_CTRL_TRSTRES = 1;
  localparam int JPS_CTRL_PA_EN = 2;
  localparam int JPS_CTRL_PB_EN = 3;
  localparam logic [3:0] JPS_CTRL_RST = 4'h2;
  // status bit positions
  localparam int JPS_STAT_TAP = 0;
  localparam int JPS_STAT_ACT = 4;
  localparam int JPS_STAT_SEC = 5;
  localparam int JPS_STAT_CHK = 6;
  localparam int JPS_STAT_PWR = 7;
  // synchroniser lanes
  localparam int JPS_NSYNC = 6;
  localparam int JPS_S_TCK = 0;
  localparam int JPS_S_TMS = 1;
  localparam int JPS_S_TDI = 2;
  localparam int JPS_S_TRST = 3;
  localparam int JPS_S_SUP = 4;
  localparam int JPS_S_FUSE = 5;
  // idle pin levels: tms and trst high, fuse, supply, tck and tdi low
  localparam logic [5:0] JPS_SYNC_RST = 6'h0A;
  // scan geometry
  localparam int JPS_IR_W = 4;
  localparam int JPS_DR_W = 16;
  localparam int JPS_SEL_W = 6;
  localparam int JPS_NETS = 64;
  localparam logic [3:0] JPS_IR_PROBE = 4'h2;
  localparam logic [3:0] JPS_IR_CHKSUM = 4'h5;
  localparam logic [3:0] JPS_IR_BYPASS = 4'hF;
  localparam logic [3:0] JPS_IR_CAPT = 4'h1;
  localparam int JPS_TLR_TCKS = 5;
  // tap states, gray steps along the usual path
  typedef enum logic [3:0] {
    JPS_TLR = 4'h0, JPS_RTI = 4'h1, JPS_SELDR = 4'h3, JPS_CAPDR = 4'h2,
    JPS_SHDR = 4'h6, JPS_EX1DR = 4'h7, JPS_PDR = 4'h5, JPS_EX2DR = 4'h4,
    JPS_UPDR = 4'hC, JPS_SELIR = 4'hD, JPS_CAPIR = 4'hF, JPS_SHIR = 4'hE,
    JPS_EX1IR = 4'hA, JPS_PIR = 4'hB, JPS_EX2IR = 4'h9, JPS_UPIR = 4'h8
  } jps_tap_t;
  typedef struct packed {
    logic pb_en;
    logic pa_en;
    logic trst_res;
    logic dedic;
  } jps_ctrl_t;
  // one pin drive: value and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } jps_pin_t;
endpackage

// ==== rtl/jps_pin_share.sv ====
// boundary-scan pin sharing, tap controller and two probe outputs.
// assumes tck/tms/tdi/trst_n and supply/fuse levels come from pins
// outside clk_sys; user drive requests and probe nets are on clk_sys.
//
// Functional notes
// - in flexible mode a low tms hands tck, tdi and tdo to the scan logic.
// - the scan pins stay in test use until the tap sits in logic reset.
// - five tck rises with tms high bring the tap to logic reset.
// - in dedicated mode tms is the plain scan mode select with no sharing.
// - a reserved trst pin low resets the scan logic, else it is user i/o.
// - the trst pin has a pull-up enabled at all times outside reset.
// - during a checksum readout tdo is driven, then returns to user i/o.
// - nets chosen by a scanned selection are routed to the probe pins.
// - each probe pin shows its selected net live, both may run at once.
// - a probe pin not enabled for probing serves as user i/o.
// - with the security fuse set no net reaches the probe pins.
// - the power-up resistor is held until the array supply is good.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module jps_pin_share (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  input wire logic array_core_supply_ok,
  input wire logic secure_fuse,
  input wire jps_pkg::jps_pin_t usr_tck,
  input wire jps_pkg::jps_pin_t usr_tdi,
  input wire jps_pkg::jps_pin_t usr_tdo,
  input wire jps_pkg::jps_pin_t usr_trst,
  input wire jps_pkg::jps_pin_t usr_pa,
  input wire jps_pkg::jps_pin_t usr_pb,
  input wire logic [63:0] probe_nets,
  input wire logic [15:0] checksum_val,
  output jps_pkg::jps_pin_t tck_pin,
  output jps_pkg::jps_pin_t tdi_pin,
  output jps_pkg::jps_pin_t tdo_pin,
  output jps_pkg::jps_pin_t trst_pin,
  output jps_pkg::jps_pin_t probe_out_a,
  output jps_pkg::jps_pin_t probe_out_b,
  output logic trst_pullup_en,
  output logic pwrup_res_en
);
  import jps_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [JPS_NSYNC-1:0] s0_q, s1_q, s2_q, f_q, fp_q, raw;
  assign raw = {secure_fuse, array_core_supply_ok, trst_n_i, tdi_i,
                tms_i, tck_i};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s0_q <= JPS_SYNC_RST;
      s1_q <= JPS_SYNC_RST;
      s2_q <= JPS_SYNC_RST;
      f_q <= JPS_SYNC_RST;
      fp_q <= JPS_SYNC_RST;
    end else begin
      s0_q <= raw;
      s1_q <= s0_q;
      s2_q <= s1_q;
      fp_q <= f_q;
      for (int i = 0; i < JPS_NSYNC; i++) begin
        if (s1_q[i] == s2_q[i]) begin
          f_q[i] <= s2_q[i];
        end
      end
    end
  end

  logic tck_rise, tck_fall, tms_f, tdi_f, trst_f, sup_f, fuse_f;
  assign tck_rise = f_q[JPS_S_TCK] & ~fp_q[JPS_S_TCK];
  assign tck_fall = ~f_q[JPS_S_TCK] & fp_q[JPS_S_TCK];
  assign tms_f = f_q[JPS_S_TMS];
  assign tdi_f = f_q[JPS_S_TDI];
  assign trst_f = f_q[JPS_S_TRST];
  assign sup_f = f_q[JPS_S_SUP];
  assign fuse_f = f_q[JPS_S_FUSE];

  // ---------------------------------------------------------------
  // control register and tap state
  // ---------------------------------------------------------------
  jps_ctrl_t ctrl_q;
  jps_tap_t tap_q, tap_d;
  logic trst_hit;
  assign trst_hit = ctrl_q.trst_res & ~trst_f;

  always_comb begin
    tap_d = tap_q;
    case (tap_q)
      JPS_TLR: tap_d = tms_f ? JPS_TLR : JPS_RTI;
      JPS_RTI: tap_d = tms_f ? JPS_SELDR : JPS_RTI;
      JPS_SELDR: tap_d = tms_f ? JPS_SELIR : JPS_CAPDR;
      JPS_CAPDR: tap_d = tms_f ? JPS_EX1DR : JPS_SHDR;
      JPS_SHDR: tap_d = tms_f ? JPS_EX1DR : JPS_SHDR;
      JPS_EX1DR: tap_d = tms_f ? JPS_UPDR : JPS_PDR;
      JPS_PDR: tap_d = tms_f ? JPS_EX2DR : JPS_PDR;
      JPS_EX2DR: tap_d = tms_f ? JPS_UPDR : JPS_SHDR;
      JPS_UPDR: tap_d = tms_f ? JPS_SELDR : JPS_RTI;
      JPS_SELIR: tap_d = tms_f ? JPS_TLR : JPS_CAPIR;
      JPS_CAPIR: tap_d = tms_f ? JPS_EX1IR : JPS_SHIR;
      JPS_SHIR: tap_d = tms_f ? JPS_EX1IR : JPS_SHIR;
      JPS_EX1IR: tap_d = tms_f ? JPS_UPIR : JPS_PIR;
      JPS_PIR: tap_d = tms_f ? JPS_EX2IR : JPS_PIR;
      JPS_EX2IR: tap_d = tms_f ? JPS_UPIR : JPS_SHIR;
      JPS_UPIR: tap_d = tms_f ? JPS_SELDR : JPS_RTI;
      default: tap_d = JPS_TLR;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tap_q <= JPS_TLR;
    end else if (trst_hit) begin
      tap_q <= JPS_TLR;
    end else if (tck_rise) begin
      tap_q <= tap_d;
    end
  end

  // ---------------------------------------------------------------
  // shared-pin takeover
  // ---------------------------------------------------------------
  logic act_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_q <= 1'b0;
    end else if (ctrl_q.dedic) begin
      act_q <= 1'b1;
    end else if (!tms_f) begin
      act_q <= 1'b1;
    end else if (tap_q == JPS_TLR) begin
      act_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // instruction and data shift paths
  // ---------------------------------------------------------------
  logic [JPS_IR_W-1:0] ir_q, irsh_q;
  logic [JPS_DR_W-1:0] drsh_q;
  logic [JPS_SEL_W-1:0] sela_q, selb_q;
  logic chk_q, tdo_bit_q;
  logic is_probe, is_chk;
  assign is_probe = (ir_q == JPS_IR_PROBE);
  assign is_chk = (ir_q == JPS_IR_CHKSUM);

  always_ff @(posedge clk_sys) begin
    if (rst || trst_hit) begin
      ir_q <= JPS_IR_BYPASS;
      irsh_q <= JPS_IR_CAPT;
      drsh_q <= '0;
      sela_q <= '0;
      selb_q <= '0;
    end else if (tck_rise) begin
      case (tap_q)
        JPS_TLR: ir_q <= JPS_IR_BYPASS;
        JPS_CAPIR: irsh_q <= JPS_IR_CAPT;
        JPS_SHIR: irsh_q <= {tdi_f, irsh_q[JPS_IR_W-1:1]};
        JPS_UPIR: ir_q <= irsh_q;
        JPS_CAPDR: begin
          if (is_chk) begin
            drsh_q <= checksum_val;
          end else begin
            drsh_q <= {4'h0, selb_q, sela_q};
          end
        end
        JPS_SHDR: begin
          if (is_probe || is_chk) begin
            drsh_q <= {tdi_f, drsh_q[JPS_DR_W-1:1]};
          end else begin
            drsh_q <= {15'h0000, tdi_f};
          end
        end
        JPS_UPDR: begin
          if (is_probe) begin
            sela_q <= drsh_q[JPS_SEL_W-1:0];
            selb_q <= drsh_q[2*JPS_SEL_W-1:JPS_SEL_W];
          end
        end
        default: ;
      endcase
    end
  end

  // checksum readout runs from capture to update
  always_ff @(posedge clk_sys) begin
    if (rst || trst_hit) begin
      chk_q <= 1'b0;
    end else if (tck_rise) begin
      if (tap_q == JPS_CAPDR && is_chk) begin
        chk_q <= 1'b1;
      end else if (tap_q == JPS_UPDR || tap_q == JPS_TLR) begin
        chk_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tdo_bit_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_bit_q <= (tap_q == JPS_SHIR) ? irsh_q[0] : drsh_q[0];
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic sec_q, shifting;
  assign shifting = (tap_q == JPS_SHDR) || (tap_q == JPS_SHIR);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_q <= 1'b0;
    end else if (fuse_f) begin
      sec_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tck_pin <= '0;
      tdi_pin <= '0;
      tdo_pin <= '0;
    end else if (act_q) begin
      tck_pin <= '0;
      tdi_pin <= '0;
      tdo_pin <= '{o: tdo_bit_q, oe: chk_q | shifting};
    end else begin
      tck_pin <= usr_tck;
      tdi_pin <= usr_tdi;
      tdo_pin <= usr_tdo;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trst_pin <= '0;
      trst_pullup_en <= 1'b0;
      pwrup_res_en <= 1'b1;
    end else begin
      trst_pin <= ctrl_q.trst_res ? '0 : usr_trst;
      trst_pullup_en <= 1'b1;
      pwrup_res_en <= ~sup_f;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      probe_out_a <= '0;
      probe_out_b <= '0;
    end else begin
      if (ctrl_q.pa_en && !sec_q) begin
        probe_out_a <= '{o: probe_nets[sela_q], oe: 1'b1};
      end else begin
        probe_out_a <= usr_pa;
      end
      if (ctrl_q.pb_en && !sec_q) begin
        probe_out_b <= '{o: probe_nets[selb_q], oe: 1'b1};
      end else begin
        probe_out_b <= usr_pb;
      end
    end
  end

  // ---------------------------------------------------------------
  // avalon-mm slave
  // ---------------------------------------------------------------
  logic req;
  assign req = avs_read | avs_write;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= JPS_CTRL_RST;
    end else if (avs_write && !avs_waitrequest &&
                 avs_address == JPS_OFS_CTRL) begin
      ctrl_q <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= '0;
      case (avs_address)
        JPS_OFS_CTRL: avs_readdata[3:0] <= ctrl_q;
        JPS_OFS_STAT: begin
          avs_readdata[JPS_STAT_TAP+:4] <= tap_q;
          avs_readdata[JPS_STAT_ACT] <= act_q;
          avs_readdata[JPS_STAT_SEC] <= sec_q;
          avs_readdata[JPS_STAT_CHK] <= chk_q;
          avs_readdata[JPS_STAT_PWR] <= sup_f;
        end
        JPS_OFS_SEL: avs_readdata[15:0] <= {2'h0, selb_q, 2'h0, sela_q};
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [2:0] hi_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (rst || trst_hit) begin
      hi_cnt_q <= '0;
    end else if (tck_rise) begin
      if (!tms_f) begin
        hi_cnt_q <= '0;
      end else if (hi_cnt_q != 3'h7) begin
        hi_cnt_q <= hi_cnt_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_tms_low_flex;
    !ctrl_q.dedic && !tms_f;
  endsequence
  sequence s_idle_reset;
    !ctrl_q.dedic && tms_f && tap_q == JPS_TLR;
  endsequence

  a_flex_takeover: assert property (s_tms_low_flex |=> act_q)
    else $error("scan pins not taken over on low tms");
  a_pin_release: assert property (s_idle_reset |=> !act_q ##1 !tck_pin.oe
    || tck_pin == $past(usr_tck))
    else $error("scan pins not released in logic reset");
  a_five_tck: assert property (hi_cnt_q >= 3'h5 |-> tap_q == JPS_TLR)
    else $error("tap not in logic reset after five high tms clocks");
  a_dedic_mode: assert property (ctrl_q.dedic |=> act_q ##1 !tck_pin.oe)
    else $error("dedicated mode lost test function");
  a_trst_init: assert property (trst_hit |=> tap_q == JPS_TLR
    && ir_q == JPS_IR_BYPASS)
    else $error("reserved trst did not reset scan logic");
  a_trst_pull: assert property ($rose(trst_pullup_en) |=> trst_pullup_en
    [*8])
    else $error("trst pull-up dropped");
  a_chk_tdo: assert property (act_q && chk_q |=> tdo_pin.oe)
    else $error("tdo not driven during checksum");
  a_probe_net: assert property (ctrl_q.pa_en && !sec_q |=>
    probe_out_a.oe && probe_out_a.o == $past(probe_nets[sela_q]))
    else $error("probe a does not show its net");
  a_probe_user: assert property (!ctrl_q.pb_en |=>
    probe_out_b == $past(usr_pb))
    else $error("probe b not returned to user i/o");
  a_secure_lock: assert property (sec_q |=> probe_out_a == $past(usr_pa)
    && probe_out_b == $past(usr_pb))
    else $error("net visible on probe pin after fuse");
  a_pwrup_hold: assert property (!sup_f |=> pwrup_res_en)
    else $error("power-up resistor released early");
  a_tap_step: assert property (tck_rise && !trst_hit && tap_q == JPS_TLR
    && !tms_f |=> tap_q == JPS_RTI)
    else $error("tap left logic reset wrongly");
endmodule

// ==== tb/jps_tester.sv ====
// partner model: external scan tester driving tck, tms, tdi and trst
// assumes the bench calls its tasks; tck stands low between frames
`timescale 1ns/10ps
module jps_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_oe,
  output logic trst_o,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_oe = 1'b0;
    trst_o = 1'b1;
  end
  // one 320 ns tck period, tdo taken late in the high phase
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #160 tck = 1'b1;
    #159 q = tdo;
    #1 tck = 1'b0;
    tdi = ~d;
  endtask
  task automatic to_reset();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
  endtask
  task automatic hold_trst(input logic drv, input logic v);
    trst_oe = drv;
    trst_o = v;
  endtask
  // from idle: shift n bits lsb first through ir or dr, back to idle
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
endmodule

// ==== tb/jps_pin_share_tb.sv ====
// testbench for the scan pin sharing and probe block
// assumes the package and the tester model are compiled first
`timescale 1ns/10ps
module jps_pin_share_tb;
  import jps_pkg::*;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, b;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic tck_i, tms_i, tdi_i, trst_n_i, array_core_supply_ok, secure_fuse;
  logic trst_oe, trst_o, trst_pullup_en, pwrup_res_en;
  jps_pin_t usr_tck, usr_tdi, usr_tdo, usr_trst, usr_pa, usr_pb;
  jps_pin_t tck_pin, tdi_pin, tdo_pin, trst_pin, probe_out_a, probe_out_b;
  logic [63:0] probe_nets;
  logic [15:0] checksum_val, so;
  int mismatches, compares;

  // released trst line rests on the pull-up
  assign trst_n_i = trst_oe ? trst_o : trst_pullup_en;

  jps_pin_share u_jps_pin_share (.clk_sys, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .tck_i,
    .tms_i, .tdi_i, .trst_n_i, .array_core_supply_ok, .secure_fuse,
    .usr_tck, .usr_tdi, .usr_tdo, .usr_trst, .usr_pa, .usr_pb, .probe_nets,
    .checksum_val, .tck_pin, .tdi_pin, .tdo_pin, .trst_pin, .probe_out_a,
    .probe_out_b, .trst_pullup_en, .pwrup_res_en);

  // an undriven tdo shows the inverse of its last value
  jps_tester u_jps_tester (.tck(tck_i), .tms(tms_i), .tdi(tdi_i), .trst_oe,
    .trst_o, .tdo(tdo_pin.oe ? tdo_pin.o : ~tdo_pin.o));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic st();
    bus(1'b0, JPS_OFS_STAT, '0);
  endtask
  task automatic tk(input logic m);
    u_jps_tester.tick(m, 1'b0, b);
    // let the filtered tck rise reach the tap before anything is read
    @(posedge clk_sys);
  endtask
  task automatic idle_reset();
    u_jps_tester.to_reset();
    repeat (4) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    chk(pwrup_res_en, 1'b1);
    bus(1'b0, JPS_OFS_CTRL, '0);
    chk(q, {28'h0, JPS_CTRL_RST});
    chk(trst_pullup_en, 1'b1);
    bus(1'b1, 4'hC, 32'hF);
    bus(1'b0, 4'hC, '0);
    chk(q, '0);
    array_core_supply_ok <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(pwrup_res_en, 1'b0);
    st();
    chk(q[7], 1'b1);
    $display("test power done");
  endtask
  task automatic t_flex();
    tk(1'b0);
    st();
    chk(q[4:0], {1'b1, JPS_RTI});
    chk(tck_pin.oe, 1'b0);
    chk(tdi_pin.oe, 1'b0);
    tk(1'b1);
    tk(1'b1);
    st();
    chk(q[4:0], {1'b1, JPS_SELIR});
    idle_reset();
    st();
    chk(q[4:0], {1'b0, JPS_TLR});
    chk({tck_pin, tdi_pin, tdo_pin}, {usr_tck, usr_tdi, usr_tdo});
    $display("test flexible done");
  endtask
  task automatic t_probe();
    bus(1'b1, JPS_OFS_CTRL, 32'hE);
    tk(1'b0);
    u_jps_tester.scan(1'b1, 4, {12'h0, JPS_IR_PROBE}, so);
    chk(so[3:0], JPS_IR_CAPT);
    // dr [5:0] is select a, [11:6] select b, upper bits ignored
    u_jps_tester.scan(1'b0, 16, 16'hCA05, so);
    @(posedge clk_sys);
    bus(1'b0, JPS_OFS_SEL, '0);
    chk(q, 32'h2805);
    chk({probe_out_a, probe_out_b}, 4'hF);
    probe_nets <= ~probe_nets;
    repeat (2) @(posedge clk_sys);
    chk({probe_out_a, probe_out_b}, 4'h5);
    bus(1'b1, JPS_OFS_CTRL, 32'h6);
    repeat (2) @(posedge clk_sys);
    chk({probe_out_a, probe_out_b}, {2'b01, usr_pb});
    $display("test probe done");
  endtask
  task automatic t_checksum();
    u_jps_tester.scan(1'b1, 4, {12'h0, JPS_IR_CHKSUM}, so);
    u_jps_tester.scan(1'b0, 16, 16'h0, so);
    chk(so, checksum_val);
    idle_reset();
    chk(tdo_pin, usr_tdo);
    $display("test checksum done");
  endtask
  task automatic t_trst();
    tk(1'b0);
    tk(1'b1);
    tk(1'b0);
    tk(1'b0);
    u_jps_tester.hold_trst(1'b1, 1'b0);
    repeat (8) @(posedge clk_sys);
    st();
    // tms is still low, so the scan pins stay taken over
    chk(q[4:0], {1'b1, JPS_TLR});
    u_jps_tester.hold_trst(1'b0, 1'b0);
    bus(1'b1, JPS_OFS_CTRL, 32'h0);
    tk(1'b0);
    u_jps_tester.hold_trst(1'b1, 1'b0);
    repeat (8) @(posedge clk_sys);
    st();
    chk(q[3:0], JPS_RTI);
    chk(trst_pin, usr_trst);
    u_jps_tester.hold_trst(1'b0, 1'b0);
    idle_reset();
    $display("test trst done");
  endtask
  task automatic t_dedic();
    bus(1'b1, JPS_OFS_CTRL, 32'h3);
    st();
    chk(q[4:0], {1'b1, JPS_TLR});
    chk(tck_pin.oe, 1'b0);
    bus(1'b1, JPS_OFS_CTRL, 32'hE);
    repeat (2) @(posedge clk_sys);
    // selections were cleared by trst, so net 0 shows
    chk(probe_out_a, 2'b11);
    $display("test dedicated done");
  endtask
  task automatic t_secure();
    secure_fuse <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({probe_out_a, probe_out_b}, {usr_pa, usr_pb});
    st();
    chk(q[5], 1'b1);
    secure_fuse <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(probe_out_a, usr_pa);
    $display("test secure done");
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #600000;
    mismatches++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, secure_fuse, array_core_supply_ok} = '0;
    avs_address = '0;
    avs_writedata = '0;
    // user side drives tck, tdi, tdo and trst as outputs, the probe pins as inputs
    {usr_tck, usr_tdi, usr_tdo, usr_trst, usr_pa, usr_pb} = 12'hF7A;
    probe_nets = 64'h0000_0100_0000_0020;
    checksum_val = 16'hA5C3;
    mismatches = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_power();
    t_flex();
    t_probe();
    t_checksum();
    t_trst();
    t_dedic();
    t_secure();
    final_report();
  end
endmodule
